// ---- tb/bus_ctl_model.sv ----
`timescale 1ns/1ps
module bus_ctl_model (
   input  wire logic       clk_in,
   input  wire logic       rst_b_in,
   input  wire logic       req_in,
   input  wire logic [3:0] wait_in,
   input  wire logic       err_in,
   output logic            done_out,
   output logic            err_out
);
   logic [4:0] cnt_r;

   // Done follows the request by the given number of wait cycles; a zero wait answers at the edge that sees it.
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_r    <= 5'h00;
         done_out <= 1'b0;
      end else begin
         done_out <= req_in ? (wait_in == 4'h0) : (cnt_r == 5'h01);
         if (req_in) begin
            cnt_r <= {1'b0, wait_in};
         end else if (cnt_r != 5'h00) begin
            cnt_r <= cnt_r - 5'h01;
         end
      end
   end

   // The error flag means nothing outside done, so it shows the inverse there.
   assign err_out = done_out ? err_in : ~err_in;
endmodule : bus_ctl_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   logic        clk_in = 1'b0, rst_b_in = 1'b0, ctl_wr_in = 1'b0, lb_req_in = 1'b0, lb_write_in = 1'b0;
   logic        lb_instr_in = 1'b0, lb_hit_in = 1'b0, region_hit_in = 1'b0, region_noncache_in = 1'b0;
   logic        region_buffered_in = 1'b0, region_wprot_in = 1'b0, bc_err_cfg = 1'b0, bc_done_in, bc_err_in;
   logic [31:0] ctl_wdata_in = 32'h0000_0000, lb_addr_in = 32'h0000_0000, ctl_rdata_out, bc_addr_out;
   logic        instr_cache_on_out, data_cache_on_out, split_config_out, user_stack_ptr_enable_out;
   logic        inval_clear_out, inval_busy_out, lb_ready_out, lb_ack_out, lb_err_out, lb_cacheable_out;
   logic        write_fault_out, bc_req_out, bc_write_out, bc_buffered_out, bc_burst_out, array_fill_we_out;
   logic [6:0]  inval_index_out;
   logic [1:0]  bc_size_out;
   logic [3:0]  bc_wait = 4'h3;
   logic        got_err, got_fault, got_fill;
   int          error_cnt = 0, check_count = 0, ack_at, n_req;

   cache_control_default_attributes dut (
      .clk_in, .rst_b_in, .ctl_wr_in, .ctl_wdata_in, .ctl_rdata_out, .instr_cache_on_out,
      .data_cache_on_out, .split_config_out, .user_stack_ptr_enable_out, .inval_clear_out,
      .inval_index_out, .inval_busy_out, .region_hit_in, .region_noncache_in, .region_buffered_in,
      .region_wprot_in, .lb_req_in, .lb_write_in, .lb_instr_in, .lb_addr_in, .lb_hit_in,
      .lb_ready_out, .lb_ack_out, .lb_err_out, .lb_cacheable_out, .write_fault_out, .bc_req_out,
      .bc_write_out, .bc_buffered_out, .bc_burst_out, .bc_size_out, .bc_addr_out, .bc_done_in,
      .bc_err_in, .array_fill_we_out
   );
   bus_ctl_model partner (
      .clk_in, .rst_b_in, .req_in(bc_req_out), .wait_in(bc_wait), .err_in(bc_err_cfg),
      .done_out(bc_done_in), .err_out(bc_err_in)
   );

   always #10 clk_in = ~clk_in;

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic test_done();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done

   task automatic wr(input logic [31:0] d);
      @(negedge clk_in);
      ctl_wr_in = 1'b1;
      ctl_wdata_in = d;
      @(negedge clk_in);
      ctl_wr_in = 1'b0;
   endtask : wr

   // One local-bus request, held until taken, then eleven cycles of answers are logged.
   task automatic acc(input logic w, input logic i, input logic [31:0] a, input logic h);
      int n;
      n = 0;
      {lb_req_in, lb_write_in, lb_instr_in, lb_addr_in, lb_hit_in} = {1'b1, w, i, a, h};
      while (lb_ready_out !== 1'b1 && n < 50) begin
         @(negedge clk_in);
         n++;
      end
      @(negedge clk_in);
      lb_req_in = 1'b0;
      {got_err, got_fault, got_fill} = 3'h0;
      ack_at = 0;
      n_req = 0;
      for (int k = 1; k < 12; k++) begin
         if (lb_ack_out === 1'b1 && ack_at == 0) ack_at = k;
         got_err |= lb_err_out;
         got_fault |= write_fault_out;
         got_fill |= array_fill_we_out;
         n_req += bc_req_out;
         @(negedge clk_in);
      end
   endtask : acc

   task automatic cfg();
      logic [31:0] d[4] = '{32'h0000_0010, 32'h8000_0000, 32'h8040_0010, 32'h8080_0000};
      logic [3:0]  e[4] = '{4'h1, 4'hE, 4'h9, 4'h4};
      for (int j = 0; j < 4; j++) begin
         wr(d[j]);
         chk({instr_cache_on_out, data_cache_on_out, split_config_out, user_stack_ptr_enable_out}, e[j]);
      end
      wr(32'h80B0_0000);
      chk(ctl_rdata_out, 32'h8080_0000);
   endtask : cfg

   task automatic sweeps();
      logic [31:0] d[6] = '{32'h8100_0000, 32'h8110_0000, 32'h8120_0000, 32'h8130_0000, 32'h8170_0000, 32'h81B0_0000};
      int          c[6] = '{128, 64, 64, 0, 128, 128};
      logic [6:0]  b[6] = '{7'h00, 7'h00, 7'h40, 7'h00, 7'h00, 7'h00};
      int          n;
      for (int j = 0; j < 6; j++) begin
         wr(d[j]);
         if (c[j] > 0) chk(inval_index_out, b[j]);
         n = 0;
         for (int k = 0; k < 200 && inval_busy_out === 1'b1; k++) begin
            n += inval_clear_out;
            @(negedge clk_in);
         end
         chk(n, c[j]);
      end
   endtask : sweeps

   task automatic fills();
      logic [1:0] s;
      for (int f = 0; f < 4; f++) begin
         for (int o = 0; o < 4; o++) begin
            wr({30'h2000_0000, f[1:0]});
            s = ((f == 1 && o > 1) || (f == 2 && o > 0)) ? 2'h0 : 2'h3;
            acc(1'b0, 1'b1, {26'h000_0040, o[1:0], 2'h0}, 1'b0);
            chk({bc_size_out, got_fill, lb_cacheable_out}, {s, 2'h3});
            chk(ack_at, 6);
         end
      end
   endtask : fills

   task automatic noncache();
      wr(32'h8000_0200);
      acc(1'b0, 1'b1, 32'h0000_2000, 1'b0);
      chk({bc_burst_out, bc_size_out, got_fill, lb_cacheable_out}, 5'h00);
      chk(bc_addr_out, 32'h0000_2000);
      wr(32'h8000_0600);
      acc(1'b0, 1'b1, 32'h0000_2000, 1'b0);
      chk({bc_burst_out, bc_size_out, got_fill, lb_cacheable_out}, 5'h1C);
      region_hit_in = 1'b1;
      acc(1'b0, 1'b0, 32'h0000_2000, 1'b0);
      chk({got_fill, lb_cacheable_out}, 2'h3);
      region_hit_in = 1'b0;
      wr(32'h8040_0000);
      acc(1'b0, 1'b0, 32'h0000_2000, 1'b1);
      chk({got_fill, lb_cacheable_out, ack_at[3:0]}, 6'h06);
   endtask : noncache

   task automatic writes();
      wr(32'h8000_0000);
      bc_err_cfg = 1'b1;
      acc(1'b1, 1'b0, 32'h0000_3000, 1'b0);
      chk({ack_at[3:0], bc_buffered_out, bc_write_out, got_fault, got_err}, {4'h6, 4'h6});
      bc_err_cfg = 1'b0;
      bc_wait = 4'h0;
      region_hit_in = 1'b1;
      region_buffered_in = 1'b1;
      acc(1'b1, 1'b0, 32'h0000_3000, 1'b0);
      chk(ack_at, 1);
      region_hit_in = 1'b0;
      wr(32'h8000_0100);
      bc_err_cfg = 1'b1;
      acc(1'b1, 1'b0, 32'h0000_3000, 1'b0);
      chk({ack_at[3:0], got_err, got_fault, bc_buffered_out}, {4'h1, 3'h3});
      bc_err_cfg = 1'b0;
      bc_wait = 4'h3;
   endtask : writes

   task automatic protect();
      wr(32'h8000_0020);
      acc(1'b1, 1'b0, 32'h0000_4000, 1'b0);
      chk({got_err, n_req[3:0]}, 5'h10);
      acc(1'b0, 1'b0, 32'h0000_4000, 1'b1);
      chk({got_err, ack_at[3:0]}, 5'h01);
   endtask : protect

   initial begin
      repeat (5) @(negedge clk_in);
      rst_b_in = 1'b1;
      @(negedge clk_in);
      chk(ctl_rdata_out, 32'h0000_0000);
      cfg();
      sweeps();
      fills();
      noncache();
      writes();
      protect();
      test_done();
   end

   // The run needs about a thousand cycles, so this margin only trips on a hang.
   initial begin
      #400000;
      error_cnt++;
      test_done();
   end
endmodule : tb_top

// ---- verilog/cache_control_default_attributes.sv ----
// Overview of operation
// R1: data-disable bit stops data caching.
// R2: split array into halves, else whole.
// R3: scope selects settable only when split.
// R4: non-split ignores selects, clears everything.
// R5: split scope selects pick halves cleared.
// R6: burst non-cacheable instruction fetches when enabled.
// R7: non-cacheable data never written to array.
// R8: defaults apply outside both regions.
// R9: cache mode bit makes defaults non-cacheable.
// R10: unbuffered write acknowledged after external cycle.
// R11: buffered write acknowledged at once.
// R12: write faults reported imprecisely.
// R13: write protect bit allows reads only.
// R14: protected write refused with access error.
// R15: bit enables separate user stack pointer.
// R16: fill field and offset set request size.
// R17: software keeps reserved bits cleared.
`timescale 1ns/1ps
module cache_control_default_attributes (
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   input  wire logic        ctl_wr_in,
   input  wire logic [31:0] ctl_wdata_in,
   output logic      [31:0] ctl_rdata_out,
   output logic             instr_cache_on_out,
   output logic             data_cache_on_out,
   output logic             split_config_out,
   output logic             user_stack_ptr_enable_out,
   output logic             inval_clear_out,
   output logic      [6:0]  inval_index_out,
   output logic             inval_busy_out,
   input  wire logic        region_hit_in,
   input  wire logic        region_noncache_in,
   input  wire logic        region_buffered_in,
   input  wire logic        region_wprot_in,
   input  wire logic        lb_req_in,
   input  wire logic        lb_write_in,
   input  wire logic        lb_instr_in,
   input  wire logic [31:0] lb_addr_in,
   input  wire logic        lb_hit_in,
   output logic             lb_ready_out,
   output logic             lb_ack_out,
   output logic             lb_err_out,
   output logic             lb_cacheable_out,
   output logic             write_fault_out,
   output logic             bc_req_out,
   output logic             bc_write_out,
   output logic             bc_buffered_out,
   output logic             bc_burst_out,
   output logic      [1:0]  bc_size_out,
   output logic      [31:0] bc_addr_out,
   input  wire logic        bc_done_in,
   input  wire logic        bc_err_in,
   output logic             array_fill_we_out
);

   logic [31:0] ctl_r;
   logic [31:0] ctl_nxt;
   logic        w_split;

   // Reserved bits are simply not stored, so a careless write cannot disturb them.
   always_comb begin
      w_split = !ctl_wdata_in[cache_ctl_pkg::BIT_INSTR_DIS] && !ctl_wdata_in[cache_ctl_pkg::BIT_DATA_DIS];
      ctl_nxt = ctl_r;
      if (ctl_wr_in) begin
         // R17: reserved bits dropped.
         ctl_nxt = ctl_wdata_in & cache_ctl_pkg::CTL_STORED_MASK;
         // R3: selects need split.
         if (!w_split) begin
            ctl_nxt[cache_ctl_pkg::BIT_INV_INSTR] = 1'b0;
            ctl_nxt[cache_ctl_pkg::BIT_INV_DATA]  = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctl_r <= cache_ctl_pkg::CTL_RESET;
      end else begin
         ctl_r <= ctl_nxt;
      end
   end

   // Debug readback; the invalidate bit is never stored and reads zero.
   assign ctl_rdata_out = ctl_r;

   logic       cfg_en;
   logic       cfg_instr_dis;
   logic       cfg_data_dis;
   logic       cfg_nc_burst;
   logic [1:0] cfg_fill;

   // Cache configuration from enable, the two disable bits, the burst bit and the fill field.
   always_comb begin
      cfg_en        = ctl_r[cache_ctl_pkg::BIT_ENABLE];
      cfg_instr_dis = ctl_r[cache_ctl_pkg::BIT_INSTR_DIS];
      cfg_data_dis  = ctl_r[cache_ctl_pkg::BIT_DATA_DIS];
      cfg_nc_burst  = ctl_r[cache_ctl_pkg::BIT_NC_BURST];
      cfg_fill      = ctl_r[cache_ctl_pkg::BIT_FILL_MSB:cache_ctl_pkg::BIT_FILL_LSB];
   end

   // R1: data disable configuration.
   assign data_cache_on_out         = cfg_en && !cfg_data_dis;
   assign instr_cache_on_out        = cfg_en && !cfg_instr_dis;
   // R2: split when neither disabled.
   assign split_config_out          = cfg_en && !cfg_instr_dis && !cfg_data_dis;
   // R15: user stack enable.
   assign user_stack_ptr_enable_out = ctl_r[cache_ctl_pkg::BIT_USP];

   inval_if inv ();

   // The sweep scope follows the value being written, so one write can set the
   // configuration and start the invalidation together.
   always_comb begin
      inv.start = ctl_wr_in && ctl_wdata_in[cache_ctl_pkg::BIT_INVALIDATE];
      inv.scope = cache_ctl_pkg::SCOPE_ALL;
      // R4: selects ignored unless split.
      if (w_split) begin
         // R5: scope from selects.
         unique case ({ctl_wdata_in[cache_ctl_pkg::BIT_INV_INSTR], ctl_wdata_in[cache_ctl_pkg::BIT_INV_DATA]})
            2'h0: inv.scope = cache_ctl_pkg::SCOPE_ALL;
            2'h1: inv.scope = cache_ctl_pkg::SCOPE_DATA;
            2'h2: inv.scope = cache_ctl_pkg::SCOPE_INSTR;
            2'h3: inv.scope = cache_ctl_pkg::SCOPE_NONE;
         endcase
      end
   end

   inval_engine u_inval (
      .clk_in   (clk_in),
      .rst_b_in (rst_b_in),
      .inv      (inv.engine)
   );

   assign inval_clear_out = inv.clr;
   assign inval_index_out = inv.index;
   assign inval_busy_out  = inv.busy;

   logic nc_eff;
   logic buf_eff;
   logic wp_eff;
   logic type_on;
   logic cacheable;
   logic wp_refuse;
   logic needs_bus;
   logic burst_now;
   logic lb_take;

   // Effective attributes of the presented reference.
   always_comb begin
      // R8: defaults outside regions.
      nc_eff    = region_hit_in ? region_noncache_in : ctl_r[cache_ctl_pkg::BIT_CACHE_MODE];
      buf_eff   = region_hit_in ? region_buffered_in : ctl_r[cache_ctl_pkg::BIT_BUF_WRITE];
      // R13: default write protect.
      wp_eff    = region_hit_in ? region_wprot_in : ctl_r[cache_ctl_pkg::BIT_WPROT];
      type_on   = lb_instr_in ? instr_cache_on_out : data_cache_on_out;
      // R9: cache mode selects cacheability.
      cacheable = !nc_eff && type_on;
      wp_refuse = lb_write_in && wp_eff;
      needs_bus = !wp_refuse && (lb_write_in || !(cacheable && lb_hit_in));
      // R6: burst non-cacheable instruction fetches.
      burst_now = cacheable || (lb_instr_in && cfg_nc_burst);
   end

   cache_ctl_pkg::bus_state_t state_r;
   cache_ctl_pkg::bus_state_t state_nxt;
   logic        wpend_r,     wpend_nxt;
   logic        ack_r,       ack_nxt;
   logic        err_r,       err_nxt;
   logic        fault_r,     fault_nxt;
   logic        fill_we_r,   fill_we_nxt;
   logic        cach_r,      cach_nxt;
   logic        bc_req_r,    bc_req_nxt;
   logic        bc_write_r,  bc_write_nxt;
   logic        bc_buf_r,    bc_buf_nxt;
   logic        bc_burst_r,  bc_burst_nxt;
   logic [1:0]  bc_size_r,   bc_size_nxt;
   logic [31:0] bc_addr_r,   bc_addr_nxt;

   // A posted write still in the bus controller stalls the next bus request only,
   // so read hits keep flowing while the write drains.
   assign lb_ready_out = (state_r == cache_ctl_pkg::ST_IDLE) && !inv.busy && !(wpend_r && needs_bus);
   assign lb_take      = lb_req_in && lb_ready_out;

   // Local bus sequencer.
   always_comb begin
      state_nxt    = state_r;
      wpend_nxt    = wpend_r;
      ack_nxt      = 1'b0;
      err_nxt      = 1'b0;
      fault_nxt    = 1'b0;
      fill_we_nxt  = 1'b0;
      cach_nxt     = cach_r;
      bc_req_nxt   = 1'b0;
      bc_write_nxt = bc_write_r;
      bc_buf_nxt   = bc_buf_r;
      bc_burst_nxt = bc_burst_r;
      bc_size_nxt  = bc_size_r;
      bc_addr_nxt  = bc_addr_r;
      unique case (state_r)
         cache_ctl_pkg::ST_IDLE: begin
            // R12: posted write fault reported late.
            if (wpend_r && bc_done_in) begin
               wpend_nxt = 1'b0;
               fault_nxt = bc_err_in;
            end
            if (lb_take) begin
               cach_nxt = cacheable;
               if (wp_refuse) begin
                  // R14: protected write refused.
                  err_nxt = 1'b1;
               end else if (!needs_bus) begin
                  ack_nxt = 1'b1;
               end else begin
                  bc_req_nxt   = 1'b1;
                  bc_write_nxt = lb_write_in;
                  bc_addr_nxt  = lb_addr_in;
                  bc_buf_nxt   = lb_write_in && buf_eff;
                  bc_burst_nxt = !lb_write_in && burst_now;
                  // R16: size from fill field.
                  bc_size_nxt  = (!lb_write_in && burst_now) ?
                                 cache_ctl_pkg::fill_size(cfg_fill, lb_addr_in[3:2]) : cache_ctl_pkg::SIZE_LONG;
                  if (!lb_write_in) begin
                     state_nxt = cache_ctl_pkg::ST_FILL;
                  end else if (buf_eff) begin
                     // R11: posted write acknowledged now.
                     ack_nxt   = 1'b1;
                     wpend_nxt = 1'b1;
                  end else begin
                     // R10: hold until external done.
                     state_nxt = cache_ctl_pkg::ST_WRITE;
                  end
               end
            end
         end
         cache_ctl_pkg::ST_FILL: begin
            if (bc_done_in) begin
               ack_nxt     = !bc_err_in;
               err_nxt     = bc_err_in;
               // R7: non-cacheable never enters array.
               fill_we_nxt = cach_r && !bc_err_in;
               state_nxt   = cache_ctl_pkg::ST_IDLE;
            end
         end
         cache_ctl_pkg::ST_WRITE: begin
            if (bc_done_in) begin
               ack_nxt   = 1'b1;
               // R12: write fault is imprecise.
               fault_nxt = bc_err_in;
               state_nxt = cache_ctl_pkg::ST_IDLE;
            end
         end
         default: begin
            state_nxt = cache_ctl_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r    <= cache_ctl_pkg::ST_IDLE;
         wpend_r    <= 1'b0;
         ack_r      <= 1'b0;
         err_r      <= 1'b0;
         fault_r    <= 1'b0;
         fill_we_r  <= 1'b0;
         cach_r     <= 1'b0;
         bc_req_r   <= 1'b0;
         bc_write_r <= 1'b0;
         bc_buf_r   <= 1'b0;
         bc_burst_r <= 1'b0;
         bc_size_r  <= 2'h0;
         bc_addr_r  <= 32'h0000_0000;
      end else begin
         state_r    <= state_nxt;
         wpend_r    <= wpend_nxt;
         ack_r      <= ack_nxt;
         err_r      <= err_nxt;
         fault_r    <= fault_nxt;
         fill_we_r  <= fill_we_nxt;
         cach_r     <= cach_nxt;
         bc_req_r   <= bc_req_nxt;
         bc_write_r <= bc_write_nxt;
         bc_buf_r   <= bc_buf_nxt;
         bc_burst_r <= bc_burst_nxt;
         bc_size_r  <= bc_size_nxt;
         bc_addr_r  <= bc_addr_nxt;
      end
   end

   assign lb_ack_out        = ack_r;
   assign lb_err_out        = err_r;
   assign lb_cacheable_out  = cach_r;
   assign write_fault_out   = fault_r;
   assign array_fill_we_out = fill_we_r;
   assign bc_req_out        = bc_req_r;
   assign bc_write_out      = bc_write_r;
   assign bc_buffered_out   = bc_buf_r;
   assign bc_burst_out      = bc_burst_r;
   assign bc_size_out       = bc_size_r;
   assign bc_addr_out       = bc_addr_r;

   property p_scope_split;
      @(posedge clk_in) disable iff (!rst_b_in)
      (ctl_r[cache_ctl_pkg::BIT_INV_INSTR] || ctl_r[cache_ctl_pkg::BIT_INV_DATA]) |->
         !ctl_r[cache_ctl_pkg::BIT_INSTR_DIS] && !ctl_r[cache_ctl_pkg::BIT_DATA_DIS];
   endproperty
   a_scope_split: assert property (p_scope_split) else $error("Scope select stored outside split."); // R3

   property p_data_off;
      @(posedge clk_in) disable iff (!rst_b_in)
      lb_take && !lb_instr_in && ctl_r[cache_ctl_pkg::BIT_DATA_DIS] |=> !lb_cacheable_out;
   endproperty
   a_data_off: assert property (p_data_off) else $error("Data cached while disabled."); // R1

   property p_default_nc;
      @(posedge clk_in) disable iff (!rst_b_in)
      lb_take && !region_hit_in && ctl_r[cache_ctl_pkg::BIT_CACHE_MODE] |=> !lb_cacheable_out;
   endproperty
   a_default_nc: assert property (p_default_nc) else $error("Default non-cacheable reference cached."); // R9

   property p_no_nc_fill;
      @(posedge clk_in) disable iff (!rst_b_in)
      array_fill_we_out |-> lb_cacheable_out && lb_ack_out;
   endproperty
   a_no_nc_fill: assert property (p_no_nc_fill) else $error("Non-cacheable data written to array."); // R7

   property p_wprot;
      @(posedge clk_in) disable iff (!rst_b_in)
      lb_take && lb_write_in && !region_hit_in && ctl_r[cache_ctl_pkg::BIT_WPROT] |=> lb_err_out && !bc_req_out;
   endproperty
   a_wprot: assert property (p_wprot) else $error("Protected write not refused."); // R14

   property p_posted;
      @(posedge clk_in) disable iff (!rst_b_in)
      lb_take && lb_write_in && !wp_eff && buf_eff |=> lb_ack_out && bc_req_out && bc_buffered_out;
   endproperty
   a_posted: assert property (p_posted) else $error("Posted write not acknowledged at once."); // R11

   property p_held;
      @(posedge clk_in) disable iff (!rst_b_in)
      lb_take && lb_write_in && !wp_eff && !buf_eff |=> !lb_ack_out && state_r == cache_ctl_pkg::ST_WRITE;
   endproperty
   a_held: assert property (p_held) else $error("Unbuffered write acknowledged early."); // R10

   // The held write is acknowledged exactly one cycle after the external cycle ends.
   property p_held_done;
      @(posedge clk_in) disable iff (!rst_b_in)
      state_r == cache_ctl_pkg::ST_WRITE |=> lb_ack_out == $past(bc_done_in);
   endproperty
   a_held_done: assert property (p_held_done) else $error("Held write acknowledge out of step."); // R10

   property p_burst_size;
      @(posedge clk_in) disable iff (!rst_b_in)
      lb_take && !lb_write_in && lb_instr_in && nc_eff && needs_bus |=>
         bc_burst_out == $past(cfg_nc_burst) &&
         bc_size_out == ($past(cfg_nc_burst) ? cache_ctl_pkg::fill_size($past(cfg_fill), $past(lb_addr_in[3:2]))
                                             : cache_ctl_pkg::SIZE_LONG);
   endproperty
   a_burst_size: assert property (p_burst_size) else $error("Non-cacheable fetch size wrong."); // R6

   property p_fault;
      @(posedge clk_in) disable iff (!rst_b_in)
      state_r == cache_ctl_pkg::ST_WRITE && bc_done_in && bc_err_in |=> write_fault_out && !lb_err_out;
   endproperty
   a_fault: assert property (p_fault) else $error("Write fault not reported apart."); // R12

   c_posted: cover property (@(posedge clk_in) disable iff (!rst_b_in) lb_take && lb_write_in && buf_eff);
   c_nc_burst: cover property (@(posedge clk_in) disable iff (!rst_b_in) bc_req_out && bc_burst_out && !lb_cacheable_out);
   c_inv_data: cover property (@(posedge clk_in) disable iff (!rst_b_in)
      inv.start && inv.scope == cache_ctl_pkg::SCOPE_DATA);
   c_wprot: cover property (@(posedge clk_in) disable iff (!rst_b_in) lb_err_out);

endmodule : cache_control_default_attributes

// ---- verilog/cache_ctl_pkg.sv ----
package cache_ctl_pkg;

   // Bit positions inside the control register.
   localparam int BIT_ENABLE     = 31;
   localparam int BIT_INVALIDATE = 24;
   localparam int BIT_INSTR_DIS  = 23;
   localparam int BIT_DATA_DIS   = 22;
   localparam int BIT_INV_INSTR  = 21;
   localparam int BIT_INV_DATA   = 20;
   localparam int BIT_NC_BURST   = 10;
   localparam int BIT_CACHE_MODE = 9;
   localparam int BIT_BUF_WRITE  = 8;
   localparam int BIT_WPROT      = 5;
   localparam int BIT_USP        = 4;
   localparam int BIT_FILL_MSB   = 1;
   localparam int BIT_FILL_LSB   = 0;

   // Reset value and the set of bits that are really stored.
   localparam logic [31:0] CTL_RESET       = 32'h0000_0000;
   localparam logic [31:0] CTL_STORED_MASK = 32'h80F0_0733;

   // Tag array geometry: a whole sweep and a half sweep.
   localparam logic [7:0] ENTRIES_ALL  = 8'h80;
   localparam logic [7:0] ENTRIES_HALF = 8'h40;
   localparam logic [6:0] INDEX_ZERO   = 7'h00;
   localparam logic [6:0] INSTR_BASE   = 7'h40;

   // Request sizes sent to the bus controller.
   localparam logic [1:0] SIZE_LONG = 2'h0;
   localparam logic [1:0] SIZE_LINE = 2'h3;

   typedef enum logic [3:0] {
      SCOPE_NONE  = 4'h1,
      SCOPE_DATA  = 4'h2,
      SCOPE_INSTR = 4'h4,
      SCOPE_ALL   = 4'h8
   } inval_scope_t;

   typedef enum logic [2:0] {
      ST_IDLE  = 3'h1,
      ST_FILL  = 3'h2,
      ST_WRITE = 3'h4
   } bus_state_t;

   // Fill size from the fill field and the longword offset of the miss.
   function automatic logic [1:0] fill_size(input logic [1:0] field, input logic [1:0] offset);
      logic [1:0] size;
      size = SIZE_LINE;
      unique case (field)
         2'h0:    size = SIZE_LINE;
         2'h1:    size = (offset < 2'h2) ? SIZE_LINE : SIZE_LONG;
         2'h2:    size = (offset == 2'h0) ? SIZE_LINE : SIZE_LONG;
         2'h3:    size = SIZE_LINE;
      endcase
      return size;
   endfunction : fill_size

endpackage : cache_ctl_pkg

// ---- verilog/inval_engine.sv ----
`timescale 1ns/1ps
module inval_engine (
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   inval_if.engine   inv
);

   logic       busy_r;
   logic       busy_nxt;
   logic [6:0] idx_r;
   logic [6:0] idx_nxt;
   logic [7:0] left_r;
   logic [7:0] left_nxt;

   // One tag entry is cleared per cycle; a start while busy is dropped.
   always_comb begin
      busy_nxt = busy_r;
      idx_nxt  = idx_r;
      left_nxt = left_r;
      if (busy_r) begin
         idx_nxt  = idx_r + 7'h01;
         left_nxt = left_r - 8'h01;
         busy_nxt = (left_r != 8'h01);
      end else if (inv.start) begin
         unique case (inv.scope)
            // R5: both halves.
            cache_ctl_pkg::SCOPE_ALL: begin
               busy_nxt = 1'b1;
               idx_nxt  = cache_ctl_pkg::INDEX_ZERO;
               left_nxt = cache_ctl_pkg::ENTRIES_ALL;
            end
            // R5: data half only.
            cache_ctl_pkg::SCOPE_DATA: begin
               busy_nxt = 1'b1;
               idx_nxt  = cache_ctl_pkg::INDEX_ZERO;
               left_nxt = cache_ctl_pkg::ENTRIES_HALF;
            end
            // R5: instruction half only.
            cache_ctl_pkg::SCOPE_INSTR: begin
               busy_nxt = 1'b1;
               idx_nxt  = cache_ctl_pkg::INSTR_BASE;
               left_nxt = cache_ctl_pkg::ENTRIES_HALF;
            end
            cache_ctl_pkg::SCOPE_NONE: begin
               busy_nxt = 1'b0;
            end
            default: begin
               busy_nxt = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         busy_r <= 1'b0;
         idx_r  <= 7'h00;
         left_r <= 8'h00;
      end else begin
         busy_r <= busy_nxt;
         idx_r  <= idx_nxt;
         left_r <= left_nxt;
      end
   end

   assign inv.busy  = busy_r;
   assign inv.clr   = busy_r;
   assign inv.index = idx_r;

   property p_sweep_all;
      @(posedge clk_in) disable iff (!rst_b_in)
      inv.start && !busy_r && inv.scope == cache_ctl_pkg::SCOPE_ALL |-> ##128 busy_r ##1 !busy_r;
   endproperty
   a_sweep_all: assert property (p_sweep_all) else $error("Full sweep is not 128 cycles."); // R4

   property p_sweep_data;
      @(posedge clk_in) disable iff (!rst_b_in)
      inv.start && !busy_r && inv.scope == cache_ctl_pkg::SCOPE_DATA |=> idx_r == 7'h00 ##63 busy_r ##1 !busy_r;
   endproperty
   a_sweep_data: assert property (p_sweep_data) else $error("Data sweep is wrong."); // R5

   property p_sweep_instr;
      @(posedge clk_in) disable iff (!rst_b_in)
      inv.start && !busy_r && inv.scope == cache_ctl_pkg::SCOPE_INSTR |=> idx_r == 7'h40 ##63 idx_r == 7'h7F;
   endproperty
   a_sweep_instr: assert property (p_sweep_instr) else $error("Instruction sweep is wrong."); // R5

endmodule : inval_engine

// ---- verilog/inval_if.sv ----
`timescale 1ns/1ps
interface inval_if;
   logic                        start;
   cache_ctl_pkg::inval_scope_t scope;
   logic                        busy;
   logic                        clr;
   logic [6:0]                  index;
   modport ctrl   (output start, output scope, input busy, input clr, input index);
   modport engine (input start, input scope, output busy, output clr, output index);
endinterface : inval_if
